// ---- src/uart_irq_pkg.sv ----
// Purpose: shared constants and carriers for the serial port interrupt and queue control block
// Assumes: APB register access with 32-bit words, one register per aligned word
// Notes:   register indices are kept; byte address is four times the index
package uart_irq_pkg;

  // register indices and byte address scaling
  localparam logic [2:0] IDX_DATA       = 3'h0;   // receive/transmit data or divisor low
  localparam logic [2:0] IDX_ENABLE     = 3'h1;   // interrupt_enable or divisor high
  localparam logic [2:0] IDX_IDENT      = 3'h2;   // interrupt_identification / queue_control
  localparam logic [2:0] IDX_LINE_CTRL  = 3'h3;
  localparam logic [2:0] IDX_LINE_STAT  = 3'h5;
  localparam logic [2:0] IDX_MODEM_STAT = 3'h6;
  localparam int         ADDR_SHIFT     = 2;

  // interrupt_enable bits
  localparam int IE_RDA   = 0;
  localparam int IE_TRANSMIT_HOLDING_EMPTY  = 1;
  localparam int IE_LS    = 2;
  localparam int IE_MODEM = 3;
  localparam logic [3:0] IE_RESET = 4'h0;

  // queue_control bits
  localparam int QC_ENABLE   = 0;
  localparam int QC_RX_FLUSH = 1;
  localparam int QC_TX_FLUSH = 2;
  localparam int QC_TRIG_LO  = 6;
  localparam int QC_TRIG_HI  = 7;

  // line control divisor access bit
  localparam int LC_DIV_ACCESS = 7;
  localparam logic [7:0] LC_RESET = 8'h00;

  // identification codes in bits 3..0
  localparam logic [3:0] ID_NONE    = 4'h1;
  localparam logic [3:0] ID_LINE    = 4'h6;
  localparam logic [3:0] ID_RDA     = 4'h4;
  localparam logic [3:0] ID_TIMEOUT = 4'hC;
  localparam logic [3:0] ID_TRANSMIT_HOLDING_EMPTY    = 4'h2;
  localparam logic [3:0] ID_MODEM   = 4'h0;
  localparam logic [1:0] ID_FIFO_ON = 2'h3;

  // receive trigger fill levels
  localparam logic [4:0] TRIG_LVL0 = 5'h01;
  localparam logic [4:0] TRIG_LVL1 = 5'h04;
  localparam logic [4:0] TRIG_LVL2 = 5'h08;
  localparam logic [4:0] TRIG_LVL3 = 5'h0E;

  // character times without receive activity before timeout
  localparam logic [2:0] TIMEOUT_CHARS = 3'h4;

  // event inputs from the serial datapath
  typedef struct packed {
    logic       line_error;   // overrun, parity, framing or break held in line_status
    logic       modem_delta;  // a modem_status delta bit is set
    logic       tx_empty;     // transmit_holding empty level
    logic       rx_activity;  // pulse: character entered or left the receive queue
    logic       char_tick;    // pulse: one character time elapsed
    logic [4:0] rx_count;     // characters held in receive queue or holding register
  } uart_events_s;

  // control outputs to the serial datapath
  typedef struct packed {
    logic        fifo_enable;
    logic        rx_flush;      // one-cycle pulse
    logic        tx_flush;      // one-cycle pulse
    logic [4:0]  rx_trigger;
    logic [7:0]  line_control;
    logic [15:0] divisor;
  } uart_ctrl_s;

endpackage : uart_irq_pkg

// ---- src/uart_interrupt_fifo_control.sv ----
// Purpose: interrupt enable, prioritised identification and queue control of a serial port
// Assumes: APB slave with zero wait states; datapath events synchronous to clk_sys
// Notes:   data, line status and modem status contents come from the datapath as inputs
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps

// How it works
// - modem status interrupt passes only while enable bit 3 is set
// - line status interrupt (overrun, parity, framing, break) needs enable bit 2
// - transmit holding empty interrupt needs enable bit 1
// - received data interrupt needs enable bit 0; bits 7-4 reserved, reset clears
// - interrupt_enable sits at index 1, reachable only with divisor access clear
// - priority: line status, received data or timeout, transmit empty, modem status
// - identification read shows one snapshot; new interrupts wait until access completes
// - identification bit 0 is low when an enabled interrupt is pending
// - bits 3-1 encode the highest source: 011, 010, 110, 001, 000
// - bit 3 is zero outside queue mode; set with bit 2 on timeout
// - timeout after four idle character times with data queued; buffer read clears
// - identification bits 4 and 5 always read zero
// - identification bits 6 and 7 read one while queues are enabled
// - queue_control write and identification read share index 2
// - queue_control bits 7-6 choose the receive trigger fill level
// - queue_control bit 3 has no effect on the channel
// - writing one to bit 2 flushes the transmit queue; self clearing
// - writing one to bit 1 flushes the receive queue only; self clearing
// - bit 0 set enables both queues
// - bit 0 cleared disables and empties both queues
// - leaving queue mode clears all queue_control contents
// - trigger codes 00, 01, 10, 11 mean 1, 4, 8, 14 bytes
// - line control bit 7 redirects indices 0 and 1 to the divisor latches
module uart_interrupt_fifo_control
  import uart_irq_pkg::*;
#(
  parameter int ADDR_W = 5
) (
  input  wire logic                     clk_sys,
  input  wire logic                     arst_n,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [ADDR_W-1:0]        paddr,
  input  wire logic [31:0]              pwdata,
  output logic                          pready,
  output logic [31:0]                   prdata,
  output logic                          pslverr,
  input  wire uart_irq_pkg::uart_events_s events,
  input  wire logic [7:0]               rx_data,
  input  wire logic [7:0]               line_status,
  input  wire logic [7:0]               modem_status,
  output uart_irq_pkg::uart_ctrl_s      ctrl,
  output logic                          tx_write,
  output logic [7:0]                    tx_data,
  output logic                          rx_read,
  output logic                          line_status_read,
  output logic                          modem_status_read,
  output logic                          irq
);

  if (ADDR_W < ADDR_SHIFT + 3) begin : g_addr_check
    $error("ADDR_W too small for register map");
  end

  // register state
  logic [3:0]  ie_q;
  logic [7:0]  lc_q;
  logic [15:0] div_q;
  logic        qen_q;
  logic [1:0]  trig_q;
  logic        rx_flush_q;
  logic        tx_flush_q;
  logic        transmit_holding_empty_q;
  logic        tx_empty_q;
  logic [2:0]  idle_q;
  logic        tmo_q;
  logic [3:0]  id_snap_q;
  logic        irq_q;
  logic [31:0] rdata_q;
  logic        tx_write_q;
  logic [7:0]  tx_data_q;

  // trigger code to fill level
  function automatic logic [4:0] trig_level(input logic [1:0] code);
    case (code)
      2'b00:   trig_level = TRIG_LVL0;
      2'b01:   trig_level = TRIG_LVL1;
      2'b10:   trig_level = TRIG_LVL2;
      default: trig_level = TRIG_LVL3;
    endcase
  endfunction : trig_level

  // bus phase and address decode
  wire logic [2:0] idx      = paddr[ADDR_SHIFT+2:ADDR_SHIFT];
  wire logic       aligned  = (paddr[ADDR_SHIFT-1:0] == '0)
                              && ((paddr >> (ADDR_SHIFT + 3)) == '0);
  wire logic       setup    = psel & ~penable;
  wire logic       access   = psel & penable;
  wire logic       div_sel  = lc_q[LC_DIV_ACCESS];
  wire logic       hit_data = (idx == IDX_DATA) & ~div_sel;
  wire logic       hit_ie   = (idx == IDX_ENABLE) & ~div_sel;
  wire logic       hit_dll  = (idx == IDX_DATA) & div_sel;
  wire logic       hit_dlm  = (idx == IDX_ENABLE) & div_sel;
  wire logic       hit_id   = (idx == IDX_IDENT);
  wire logic       hit_lc   = (idx == IDX_LINE_CTRL);
  wire logic       hit_ls   = (idx == IDX_LINE_STAT);
  wire logic       hit_ms   = (idx == IDX_MODEM_STAT);
  wire logic       mapped   = aligned & (hit_data | hit_ie | hit_dll | hit_dlm | hit_id
                                         | hit_lc | hit_ls | hit_ms);
  wire logic       wr_done  = access & pwrite & mapped;
  wire logic       rd_done  = access & ~pwrite & mapped;
  wire logic       id_setup = setup & ~pwrite & aligned & hit_id;
  wire logic       id_busy  = psel & ~pwrite & aligned & hit_id;

  // receive side conditions
  wire logic       rx_nonempty = (events.rx_count != '0);
  wire logic [4:0] rx_trig     = trig_level(trig_q);
  wire logic       rda_level   = qen_q ? (events.rx_count >= rx_trig) : rx_nonempty;
  wire logic       rb_read     = rd_done & hit_data;

  // enabled sources and priority
  wire logic p_ls    = ie_q[IE_LS] & events.line_error;
  wire logic p_tmo   = ie_q[IE_RDA] & tmo_q;
  wire logic p_rda   = ie_q[IE_RDA] & rda_level;
  wire logic p_transmit_holding_empty  = ie_q[IE_TRANSMIT_HOLDING_EMPTY] & transmit_holding_empty_q;
  wire logic p_modem = ie_q[IE_MODEM] & events.modem_delta;
  wire logic any_p   = p_ls | p_tmo | p_rda | p_transmit_holding_empty | p_modem;

  // priority encoder, line status first, modem status last
  wire logic [3:0] id_live = p_ls   ? ID_LINE :
                             p_rda  ? ID_RDA :
                             p_tmo  ? (qen_q ? ID_TIMEOUT : ID_RDA) :
                             p_transmit_holding_empty ? ID_TRANSMIT_HOLDING_EMPTY :
                             p_modem ? ID_MODEM : ID_NONE;
  wire logic [7:0] id_byte = {(qen_q ? ID_FIFO_ON : 2'b00),
                              2'b00,
                              id_snap_q[3] & qen_q,
                              id_snap_q[2:0]};

  // combinational read mux
  wire logic [7:0] rd_byte = hit_data ? rx_data :
                             hit_ie   ? {4'h0, ie_q} :
                             hit_dll  ? div_q[7:0] :
                             hit_dlm  ? div_q[15:8] :
                             hit_id   ? id_byte :
                             hit_lc   ? lc_q :
                             hit_ls   ? line_status :
                             hit_ms   ? modem_status : 8'h00;

  // interrupt enable, line control and divisor latches
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ie_q  <= IE_RESET;
      lc_q  <= LC_RESET;
      div_q <= 16'h0000;
    end else if (wr_done) begin
      if (hit_ie)  ie_q <= pwdata[3:0];
      if (hit_lc)  lc_q <= pwdata[7:0];
      if (hit_dll) div_q[7:0] <= pwdata[7:0];
      if (hit_dlm) div_q[15:8] <= pwdata[7:0];
    end
  end

  // queue control: enable, trigger, self clearing flushes
  wire logic qc_wr  = wr_done & hit_id;
  wire logic qc_on  = pwdata[QC_ENABLE];                          // bit 3 never read
  wire logic qc_chg = qc_wr & (qc_on != qen_q);
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      qen_q      <= 1'b0;
      trig_q     <= 2'b00;
      rx_flush_q <= 1'b0;
      tx_flush_q <= 1'b0;
    end else begin
      rx_flush_q <= 1'b0;
      tx_flush_q <= 1'b0;
      if (qc_wr && qc_on) begin
        qen_q      <= 1'b1;
        trig_q     <= pwdata[QC_TRIG_HI:QC_TRIG_LO];
        rx_flush_q <= pwdata[QC_RX_FLUSH] | qc_chg;
        tx_flush_q <= pwdata[QC_TX_FLUSH] | qc_chg;
      end else if (qc_wr) begin
        qen_q      <= 1'b0;
        trig_q     <= 2'b00;
        rx_flush_q <= qc_chg;
        tx_flush_q <= qc_chg;
      end
    end
  end

  // transmit empty flag: set on rising empty, cleared by id read or data write
  wire logic transmit_holding_empty_rise = events.tx_empty & ~tx_empty_q;
  wire logic transmit_holding_empty_clr  = (rd_done & hit_id & (id_snap_q == ID_TRANSMIT_HOLDING_EMPTY))
                         | (wr_done & hit_data);
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tx_empty_q <= 1'b0;
      transmit_holding_empty_q     <= 1'b0;
    end else begin
      tx_empty_q <= events.tx_empty;
      if (transmit_holding_empty_rise)     transmit_holding_empty_q <= 1'b1;                          // set wins over clear
      else if (transmit_holding_empty_clr) transmit_holding_empty_q <= 1'b0;
    end
  end

  // character timeout: idle character times counted while data is queued
  wire logic idle_rst = ~qen_q | ~rx_nonempty | events.rx_activity | rb_read;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      idle_q <= 3'h0;
      tmo_q  <= 1'b0;
    end else if (idle_rst) begin
      idle_q <= 3'h0;
      tmo_q  <= 1'b0;
    end else if (events.char_tick && idle_q != TIMEOUT_CHARS) begin
      idle_q <= idle_q + 3'h1;
      tmo_q  <= (idle_q + 3'h1 == TIMEOUT_CHARS);
    end
  end

  // identification snapshot; frozen while the host reads it
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      id_snap_q <= ID_NONE;
      irq_q     <= 1'b0;
    end else if (!id_busy || id_setup) begin
      id_snap_q <= id_live;
      irq_q     <= any_p;
    end
  end

  // registered read data and transmit data strobe
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q    <= 32'h0000_0000;
      tx_write_q <= 1'b0;
      tx_data_q  <= 8'h00;
    end else begin
      tx_write_q <= wr_done & hit_data;
      if (wr_done && hit_data) tx_data_q <= pwdata[7:0];
      if (setup && !pwrite) rdata_q <= {24'h000000, rd_byte};
    end
  end

  // bus answers and outputs
  assign pready            = 1'b1;
  assign pslverr           = access & ~mapped;
  assign prdata            = (access && !pwrite && hit_id && aligned)
                             ? {24'h000000, id_byte} : rdata_q;
  assign irq               = irq_q;
  assign tx_write          = tx_write_q;
  assign tx_data           = tx_data_q;
  assign rx_read           = rb_read;
  assign line_status_read  = rd_done & hit_ls;
  assign modem_status_read = rd_done & hit_ms;
  assign ctrl.fifo_enable  = qen_q;
  assign ctrl.rx_flush     = rx_flush_q;
  assign ctrl.tx_flush     = tx_flush_q;
  assign ctrl.rx_trigger   = rx_trig;
  assign ctrl.line_control = lc_q;
  assign ctrl.divisor      = div_q;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  // source gating by the enable bits
  a_modem_gate: assert property (!ie_q[IE_MODEM]
                                 |-> !p_modem)
    else $error("modem interrupt passed while disabled");

  a_ls_gate: assert property (!ie_q[IE_LS]
                              |-> !p_ls)
    else $error("line status interrupt passed while disabled");

  a_transmit_holding_empty_gate: assert property (!ie_q[IE_TRANSMIT_HOLDING_EMPTY] && !id_busy
                                |=> id_snap_q != ID_TRANSMIT_HOLDING_EMPTY)
    else $error("transmit empty reported while disabled");

  a_rda_gate: assert property (!ie_q[IE_RDA]
                               |-> !p_rda && !p_tmo)
    else $error("received data interrupt passed while disabled");

  a_ie_reserved: assert property (hit_ie
                                  |-> rd_byte[7:4] == 4'h0)
    else $error("reserved enable bits read nonzero");

  // register map
  a_ie_write: assert property (wr_done && hit_ie
                               |=> ie_q == $past(pwdata[3:0]))
    else $error("interrupt enable write lost");

  a_div_block: assert property (div_sel && wr_done && idx == IDX_ENABLE
                                |=> $stable(ie_q))
    else $error("enable written while divisor access set");

  // priority and identification codes
  a_line_first: assert property (p_ls && !id_busy
                                 |=> id_snap_q == ID_LINE)
    else $error("line status not reported first");

  a_rda_second: assert property (p_rda && !p_ls && !id_busy
                                 |=> id_snap_q == ID_RDA)
    else $error("received data not reported second");

  a_tmo_code: assert property (p_tmo && !p_ls && !p_rda && qen_q && !id_busy
                               |=> id_snap_q == ID_TIMEOUT)
    else $error("timeout code wrong");

  a_transmit_holding_empty_third: assert property (p_transmit_holding_empty && !p_ls && !p_rda && !p_tmo && !id_busy
                                 |=> id_snap_q == ID_TRANSMIT_HOLDING_EMPTY)
    else $error("transmit empty not reported third");

  a_modem_last: assert property (p_modem && !p_ls && !p_rda && !p_tmo && !p_transmit_holding_empty
                                 && !id_busy
                                 |=> id_snap_q == ID_MODEM)
    else $error("modem status not reported last");

  a_snap_hold: assert property (id_busy && !id_setup
                                |=> $stable(id_snap_q))
    else $error("identification changed during access");

  a_pend_low: assert property (!id_busy ##1 !id_busy
                               |-> id_snap_q[0] == !$past(any_p))
    else $error("pending bit wrong");

  a_pend_none: assert property (!any_p && !id_busy
                                |=> id_snap_q == ID_NONE)
    else $error("no pending source but code shown");

  a_bit3_off: assert property (!qen_q
                               |-> !id_byte[3] && id_byte[7:4] == 4'h0)
    else $error("queue-mode bits set outside queue mode");

  a_zero_bits: assert property (1'b1
                                |-> id_byte[5:4] == 2'b00)
    else $error("identification bits 5 and 4 set");

  a_fifo_bits: assert property (qen_q
                                |-> id_byte[7:6] == ID_FIFO_ON)
    else $error("queue mode bits missing");

  // queue control
  a_trig_top: assert property (trig_q == 2'b11
                               |-> rx_trig == TRIG_LVL3)
    else $error("top trigger level wrong");

  a_tx_flush: assert property (qc_wr && qc_on && pwdata[QC_TX_FLUSH]
                               |=> tx_flush_q ##1 !tx_flush_q)
    else $error("transmit flush not a single pulse");

  a_rx_flush: assert property (qc_wr && qc_on && pwdata[QC_RX_FLUSH]
                               |=> rx_flush_q)
    else $error("receive flush missing");

  a_ctrl_bit3: assert property (qc_wr && qc_on && qen_q && !pwdata[QC_RX_FLUSH]
                                && !pwdata[QC_TX_FLUSH]
                                |=> !rx_flush_q && !tx_flush_q)
    else $error("flush without flush bit");

  a_off_clear: assert property (qc_wr && !qc_on
                                |=> !qen_q && trig_q == 2'b00)
    else $error("queue control not cleared");

  a_off_flush: assert property (qc_wr && qen_q && !qc_on
                                |=> rx_flush_q && tx_flush_q)
    else $error("queues not emptied on disable");

  // character timeout
  a_tmo_set: assert property (!idle_rst && events.char_tick
                              && idle_q == TIMEOUT_CHARS - 3'h1
                              |=> tmo_q)
    else $error("timeout not raised after idle character times");

  a_tmo_clear: assert property (rb_read
                                |=> !tmo_q)
    else $error("timeout survived buffer read");

endmodule : uart_interrupt_fifo_control

// ---- test/serial_side_model.sv ----
// Purpose: behavioural serial datapath standing behind the interrupt and queue control block
// Assumes: bench kicks are one-cycle pulses: 0 line error, 1 modem delta, 2 char in, 3 char time
// Notes:   holding register keeps one character outside queue mode, sixteen inside
`timescale 1ns/1ps
module serial_side_model
  import uart_irq_pkg::*;
(
  input  wire logic                        clk_sys,
  input  wire logic                        arst_n,
  input  wire logic [3:0]                  kick,
  input  wire logic                        tx_idle,
  input  wire uart_irq_pkg::uart_ctrl_s    ctrl,
  input  wire logic                        rx_read,
  input  wire logic                        line_status_read,
  input  wire logic                        modem_status_read,
  output uart_irq_pkg::uart_events_s       events,
  output logic [7:0]                       rx_data,
  output logic [7:0]                       line_status,
  output logic [7:0]                       modem_status
);
  logic       line_q;
  logic       modem_q;
  logic [4:0] cnt_q;
  logic [4:0] cap;

  // status sources clear only by their own read; queue empties on flush
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      line_q  <= 1'b0;
      modem_q <= 1'b0;
      cnt_q   <= 5'h00;
    end else begin
      if (kick[0]) line_q <= 1'b1;
      else if (line_status_read) line_q <= 1'b0;
      if (kick[1]) modem_q <= 1'b1;
      else if (modem_status_read) modem_q <= 1'b0;
      if (ctrl.rx_flush) cnt_q <= 5'h00;
      else if (kick[2] && cnt_q < cap) cnt_q <= cnt_q + 5'h01;
      else if (rx_read && cnt_q != 5'h00) cnt_q <= cnt_q - 5'h01;
    end
  end

  // event bundle and register contents seen by the block
  assign cap          = ctrl.fifo_enable ? 5'h10 : 5'h01;
  assign events       = {line_q, modem_q, tx_idle, kick[2] | rx_read, kick[3], cnt_q};
  assign rx_data      = {3'h0, cnt_q};
  assign line_status  = {6'h00, line_q, 1'b0};
  assign modem_status = {7'h00, modem_q};
endmodule : serial_side_model

// ---- test/testbench.sv ----
// Purpose: self-checking bench for interrupt identification and queue control over APB
// Assumes: zero wait state slave, but the master still waits for pready
// Notes:   flush pulses are counted by a monitor and compared for each queue_control write made through qc
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module testbench;
  import uart_irq_pkg::*;
  logic clk_sys = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [4:0]   paddr = 5'h00;
  logic [31:0]  pwdata = 32'h0, prdata;
  logic         pready, pslverr, slv, irq, tx_write, rx_read, ls_rd, ms_rd;
  logic [3:0]   kick = 4'h0;
  logic         tx_idle = 1'b0;
  logic [7:0]   rx_data, line_status, modem_status, q, tx_data;
  uart_events_s events;
  uart_ctrl_s   ctrl;
  int           errors = 0, compares = 0, rxf = 0, txf = 0;
  logic [7:0]   code [4] = '{8'h04, 8'h02, 8'h06, 8'h00};
  logic [4:0]   lvl [4] = '{5'h01, 5'h04, 5'h08, 5'h0E};

  uart_interrupt_fifo_control #(.ADDR_W(5)) uut (.clk_sys(clk_sys), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .events(events), .rx_data(rx_data),
    .line_status(line_status), .modem_status(modem_status), .ctrl(ctrl),
    .tx_write(tx_write), .tx_data(tx_data), .rx_read(rx_read), .line_status_read(ls_rd),
    .modem_status_read(ms_rd), .irq(irq));
  serial_side_model mdl (.clk_sys(clk_sys), .arst_n(arst_n), .kick(kick), .tx_idle(tx_idle),
    .ctrl(ctrl), .rx_read(rx_read), .line_status_read(ls_rd), .modem_status_read(ms_rd),
    .events(events), .rx_data(rx_data), .line_status(line_status), .modem_status(modem_status));

  // clock, reset and flush pulse counting
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
  end
  always @(posedge clk_sys) begin
    rxf <= rxf + int'(ctrl.rx_flush);
    txf <= txf + int'(ctrl.tx_flush);
  end

  // one APB transfer: setup, access until pready, then one idle cycle
  task automatic apb(input logic wr, input logic [2:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= {idx, 2'b00}; pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) errors++;
    q = prdata[7:0];
    slv = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task automatic rdc(input logic [2:0] idx, input logic [7:0] e, input string nm);
    apb(1'b0, idx, 8'h00);
    `CHK(nm, e, q);
  endtask : rdc
  task automatic ev(input int k);
    kick[k] <= 1'b1;
    @(posedge clk_sys);
    kick <= 4'h0;
    @(posedge clk_sys);
  endtask : ev
  task automatic toggle_tx;
    tx_idle <= 1'b0;
    @(posedge clk_sys);
    tx_idle <= 1'b1;
    @(posedge clk_sys);
  endtask : toggle_tx
  task automatic raise(input int i);
    if (i == 0) ev(2);
    else if (i == 1) toggle_tx();
    else ev(i == 2 ? 0 : 1);
  endtask : raise
  task automatic qc(input logic [7:0] v, input int er, input int et);
    int r0, t0;
    r0 = rxf;
    t0 = txf;
    apb(1'b1, IDX_IDENT, v);
    @(posedge clk_sys);
    `CHK("rx flush", er, rxf - r0);
    `CHK("tx flush", et, txf - t0);
  endtask : qc
  task automatic close_out;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out

  // watchdog cuts a hang short
  initial begin
    repeat (5000) @(posedge clk_sys);
    errors++;
    close_out();
  end

  // test sequence
  initial begin
    @(posedge arst_n);
    @(posedge clk_sys);
    rdc(IDX_IDENT, 8'h01, "ident reset");
    rdc(IDX_ENABLE, 8'h00, "enable reset");
    rdc(3'h4, 8'h00, "unmapped read");
    `CHK("unmapped err", 1'b1, slv);
    apb(1'b1, IDX_ENABLE, 8'h0F);
    rdc(IDX_ENABLE, 8'h0F, "enable rw");
    apb(1'b1, IDX_LINE_CTRL, 8'h80);
    apb(1'b1, IDX_ENABLE, 8'h55);
    `CHK("divisor high", 8'h55, ctrl.divisor[15:8]);
    apb(1'b1, IDX_LINE_CTRL, 8'h00);
    rdc(IDX_ENABLE, 8'h0F, "enable kept");
    $display("test registers done");
    // each source masked by its own enable bit, then shown with its code
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, IDX_ENABLE, 8'h0F & ~(8'h01 << i));
      raise(i);
      rdc(IDX_IDENT, 8'h01, "masked");
      `CHK("irq masked", 1'b0, irq);
      apb(1'b1, IDX_ENABLE, 8'h0F);
      @(posedge clk_sys);
      `CHK("irq on", 1'b1, irq);
      rdc(IDX_IDENT, code[i], "source code");
      if (i != 1) apb(1'b0, i == 0 ? IDX_DATA : (i == 2 ? IDX_LINE_STAT : IDX_MODEM_STAT), 8'h00);
      rdc(IDX_IDENT, 8'h01, "source cleared");
    end
    $display("test masking done");
    fork
      rdc(IDX_IDENT, 8'h01, "ident frozen");
      ev(0);
    join
    rdc(IDX_IDENT, 8'h06, "line after read");
    ev(1);
    toggle_tx();
    ev(2);
    rdc(IDX_IDENT, 8'h06, "line first");
    apb(1'b0, IDX_LINE_STAT, 8'h00);
    rdc(IDX_IDENT, 8'h04, "data second");
    apb(1'b0, IDX_DATA, 8'h00);
    rdc(IDX_IDENT, 8'h02, "empty third");
    rdc(IDX_IDENT, 8'h00, "modem last");
    apb(1'b0, IDX_MODEM_STAT, 8'h00);
    rdc(IDX_IDENT, 8'h01, "all clear");
    `CHK("irq idle", 1'b0, irq);
    $display("test priority done");
    qc(8'hC1, 1, 1);
    `CHK("queue on", 1'b1, ctrl.fifo_enable);
    `CHK("trigger 14", 5'h0E, ctrl.rx_trigger);
    rdc(IDX_IDENT, 8'hC1, "queue mode id");
    qc(8'h03, 1, 0);
    qc(8'h05, 0, 1);
    qc(8'h09, 0, 0);
    qc(8'h01, 0, 0);
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, IDX_IDENT, {c[1:0], 6'h01});
      `CHK("trigger level", lvl[c], ctrl.rx_trigger);
    end
    ev(2);
    repeat (3) ev(3);
    rdc(IDX_IDENT, 8'hC1, "three idle");
    ev(3);
    rdc(IDX_IDENT, 8'hCC, "timeout");
    apb(1'b0, IDX_DATA, 8'h00);
    rdc(IDX_IDENT, 8'hC1, "timeout cleared");
    apb(1'b1, IDX_IDENT, 8'h01);
    ev(2);
    rdc(IDX_IDENT, 8'hC4, "data at level");
    apb(1'b0, IDX_DATA, 8'h00);
    qc(8'h00, 1, 1);
    `CHK("queue off", 1'b0, ctrl.fifo_enable);
    `CHK("trigger cleared", 5'h01, ctrl.rx_trigger);
    apb(1'b1, IDX_IDENT, 8'hC0);
    `CHK("bits need enable", 5'h01, ctrl.rx_trigger);
    rdc(IDX_IDENT, 8'h01, "non queue id");
    $display("test queue control done");
    close_out();
  end
endmodule : testbench
